/* File: hw/ivm_defs.svh */
// constants of the interrupt vector mapper
`ifndef IVM_DEFS_SVH
`define IVM_DEFS_SVH

`define VEC_W             8
`define VEC_IDX_W         6
`define VEC_COUNT         64
`define RES_COUNT         48
`define LEVEL_IDX_W       6
`define FIXED_LEVEL_W     5
`define ADDR_W            32
`define TABLE_TOP         32'h0000_03fc
`define PERIPH_BASE       8'h10
`define NMI_FIXED_LEVEL   5'h0f

`define VEC_IAP           6
`define VEC_DAP           7
`define VEC_DATA_ERR      8
`define VEC_UNDEF         14
`define VEC_NMI           15
`define VEC_EXT_LO        16
`define VEC_EXT_HI        17
`define VEC_RELOAD_A      18
`define VEC_RELOAD_B      19
`define VEC_SER0_RX       20
`define VEC_PULSE_BASE    28
`define VEC_GEN_BASE      34
`define VEC_SER8_RX       45
`define VEC_OSC_TIMERS    46
`define VEC_CAL_SUB       47
`define VEC_CAL_RC        48
`define VEC_SER9_TX       49
`define VEC_FRT4          50
`define VEC_FRT35         51
`define VEC_SER10_RX      52
`define VEC_SER10_TX      53
`define VEC_SER11_RX      54
`define VEC_WAVE          55
`define VEC_TRIP          56
`define VEC_LAST_USED     56

`define SER_LO_CH         4
`define PULSE_GROUPS      6
`define PULSE_GROUP_CH    8
`define PULSE_DMA_GROUPS  3
`define GEN_COUNT         11

`endif

/* File: hw/ivm_pkg.sv */
// types of the interrupt vector mapper
`default_nettype none

package ivm_pkg;

    typedef enum logic [3:0] {
        CLS_NONE   = 4'b0001,
        CLS_EXC    = 4'b0010,
        CLS_NMI    = 4'b0100,
        CLS_PERIPH = 4'b1000
    } req_class_type;

endpackage : ivm_pkg

`default_nettype wire

/* File: hw/event_latch.sv */
// sticky pending bits for pulsed events, set wins over clear
`default_nettype none

module event_latch #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    output var  logic [WIDTH-1:0] pend_out
);

    if (WIDTH < 1) begin : g_chk
        $error("event_latch: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] pend_nxt;

    assign pend_nxt = (pend_out & ~clr_in) | set_in;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_out <= '0;
        end else begin
            pend_out <= pend_nxt;
        end
    end

endmodule : event_latch

`default_nettype wire

/* File: hw/lowest_first.sv */
// priority encoder, the lowest set bit wins
`default_nettype none

module lowest_first #(
    parameter int WIDTH = 64,
    parameter int IDX_W = 6
) (
    input  wire logic [WIDTH-1:0] req_in,
    output var  logic             found_out,
    output var  logic [IDX_W-1:0] idx_out
);

    if ((WIDTH < 2) || ((1 << IDX_W) < WIDTH)) begin : g_chk
        $error("lowest_first: IDX_W too narrow for WIDTH");
    end

    always_comb begin
        found_out = 1'b0;
        idx_out   = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                found_out = 1'b1;
                idx_out   = IDX_W'(i);
            end
        end
    end

endmodule : lowest_first

`default_nettype wire

/* File: hw/interrupt_vector_mapper.sv */
// maps exception, nmi and peripheral requests onto vectors, table addresses, level indices and dma requests
`default_nettype none

`include "ivm_defs.svh"

module interrupt_vector_mapper
    import ivm_pkg::*;
(
    input  wire logic                        mclk_in,
    input  wire logic                        rst_in,
    // core side
    input  wire logic [`ADDR_W-1:0]          vector_table_base_in,
    input  wire logic                        irq_ack_in,
    output var  logic                        irq_valid_out,
    output var  logic [`VEC_W-1:0]           irq_vector_out,
    output var  logic [`ADDR_W-1:0]          irq_vector_addr_out,
    output var  logic [`LEVEL_IDX_W-1:0]     irq_level_index_out,
    output var  logic                        irq_level_index_valid_out,
    output var  logic [`FIXED_LEVEL_W-1:0]   irq_fixed_level_out,
    output var  req_class_type               irq_class_out,
    // dma controller side
    output var  logic [`RES_COUNT-1:0]       dma_req_out,
    // exception events, one-cycle pulses
    input  wire logic                        instr_prot_viol_in,
    input  wire logic                        data_prot_viol_in,
    input  wire logic                        data_access_err_in,
    input  wire logic                        undef_instr_in,
    // nmi events, one-cycle pulses
    input  wire logic                        bus_diag_err_in,
    input  wire logic                        crossbar_ram_dbl_err_in,
    input  wire logic                        backup_ram_dbl_err_in,
    input  wire logic                        timing_protection_viol_in,
    // peripheral request levels
    input  wire logic [15:0]                 ext_int_in,
    input  wire logic                        low_voltage_det_in,
    input  wire logic [7:0]                  reload_timer_in,
    input  wire logic [`SER_LO_CH-1:0]       serial_lo_rx_in,
    input  wire logic [`SER_LO_CH-1:0]       serial_lo_status_in,
    input  wire logic [`SER_LO_CH-1:0]       serial_lo_tx_in,
    input  wire logic [3:0]                  serial_hi_rx_in,
    input  wire logic [3:0]                  serial_hi_status_in,
    input  wire logic [3:0]                  serial_hi_tx_in,
    input  wire logic [47:0]                 pulse_gen_in,
    input  wire logic [`GEN_COUNT-1:0]       generic_req_in,
    input  wire logic [3:0]                  capture16_in,
    input  wire logic [9:4]                  capture32_in,
    input  wire logic [5:0]                  compare16_in,
    input  wire logic [5:3]                  free_run32_in,
    input  wire logic [2:0]                  osc_stab_timer_in,
    input  wire logic                        clk_cal_sub_in,
    input  wire logic                        clk_cal_rc_in,
    input  wire logic [31:0]                 adc_done_in,
    input  wire logic [2:0]                  wave_dead_underflow_in,
    input  wire logic [2:0]                  wave_dead_reload_in,
    input  wire logic                        dead_time_trip_input_in
);

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------

    function automatic logic [`ADDR_W-1:0] vec_addr(input logic [`ADDR_W-1:0] base, input logic [`VEC_W-1:0] v);
        vec_addr = base + `TABLE_TOP - {22'h0, v, 2'b00};
    endfunction : vec_addr

    function automatic logic [`LEVEL_IDX_W-1:0] periph_index(input logic [`VEC_W-1:0] v);
        logic [`VEC_W-1:0] d;
        d = v - `PERIPH_BASE;
        periph_index = d[`LEVEL_IDX_W-1:0];
    endfunction : periph_index

    //--------------------------------------------------------------------------
    // exception and nmi pending bits
    //--------------------------------------------------------------------------

    logic [7:0] evt_set;
    logic [7:0] evt_clr;
    logic [7:0] evt_pend;
    logic       ack_exc_iap;
    logic       ack_exc_dap;
    logic       ack_exc_derr;
    logic       ack_exc_undef;
    logic       ack_nmi;
    logic       nmi_pend;

    assign evt_set = {timing_protection_viol_in, backup_ram_dbl_err_in, crossbar_ram_dbl_err_in, bus_diag_err_in,
                      undef_instr_in, data_access_err_in, data_prot_viol_in, instr_prot_viol_in};

    assign ack_exc_iap   = irq_ack_in && irq_valid_out && (irq_vector_out == `VEC_W'(`VEC_IAP));
    assign ack_exc_dap   = irq_ack_in && irq_valid_out && (irq_vector_out == `VEC_W'(`VEC_DAP));
    assign ack_exc_derr  = irq_ack_in && irq_valid_out && (irq_vector_out == `VEC_W'(`VEC_DATA_ERR));
    assign ack_exc_undef = irq_ack_in && irq_valid_out && (irq_vector_out == `VEC_W'(`VEC_UNDEF));
    assign ack_nmi       = irq_ack_in && irq_valid_out && (irq_vector_out == `VEC_W'(`VEC_NMI));

    // one nmi acknowledge retires every nmi source seen so far
    assign evt_clr = {{4{ack_nmi}}, ack_exc_undef, ack_exc_derr, ack_exc_dap, ack_exc_iap};

    event_latch #(
        .WIDTH (8)
    ) u_events (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .set_in   (evt_set),
        .clr_in   (evt_clr),
        .pend_out (evt_pend)
    );

    assign nmi_pend = |evt_pend[7:4];

    //--------------------------------------------------------------------------
    // per-vector request and dma maps
    //--------------------------------------------------------------------------

    logic [`VEC_COUNT-1:0] req_vec;
    logic [`RES_COUNT-1:0] dma_vec;

    assign req_vec[5:0]             = 6'h00;
    assign req_vec[`VEC_IAP]        = evt_pend[0];
    assign req_vec[`VEC_DAP]        = evt_pend[1];
    assign req_vec[`VEC_DATA_ERR]   = evt_pend[2];
    assign req_vec[13:9]            = 5'h00;
    assign req_vec[`VEC_UNDEF]      = evt_pend[3];
    assign req_vec[`VEC_NMI]        = nmi_pend;

    assign req_vec[`VEC_EXT_LO]     = |ext_int_in[7:0];
    assign dma_vec[0]               = |ext_int_in[7:0];
    assign req_vec[`VEC_EXT_HI]     = |ext_int_in[15:8] | low_voltage_det_in;
    assign dma_vec[1]               = |ext_int_in[15:8];

    assign req_vec[`VEC_RELOAD_A]   = reload_timer_in[0] | reload_timer_in[1] | reload_timer_in[4] | reload_timer_in[5];
    assign dma_vec[2]               = reload_timer_in[0] | reload_timer_in[1];
    assign req_vec[`VEC_RELOAD_B]   = reload_timer_in[2] | reload_timer_in[3] | reload_timer_in[6] | reload_timer_in[7];
    assign dma_vec[3]               = reload_timer_in[2] | reload_timer_in[3];

    // low serial channels: receive/status then transmit on consecutive vectors
    for (genvar k = 0; k < `SER_LO_CH; k++) begin : g_ser_lo
        localparam int RXV = `VEC_SER0_RX + 2 * k;
        assign req_vec[RXV]       = serial_lo_rx_in[k] | serial_lo_status_in[k];
        assign dma_vec[RXV - 16]  = serial_lo_rx_in[k];
        assign req_vec[RXV + 1]   = serial_lo_tx_in[k];
        assign dma_vec[RXV - 15]  = serial_lo_tx_in[k];
    end

    // pulse generators in groups of eight channels
    for (genvar g = 0; g < `PULSE_GROUPS; g++) begin : g_pulse
        localparam int PV = `VEC_PULSE_BASE + g;
        assign req_vec[PV] = |pulse_gen_in[g*`PULSE_GROUP_CH +: `PULSE_GROUP_CH];
        if (g < `PULSE_DMA_GROUPS) begin : g_dma
            assign dma_vec[PV - 16] = |pulse_gen_in[g*`PULSE_GROUP_CH +: `PULSE_GROUP_CH];
        end else begin : g_nodma
            assign dma_vec[PV - 16] = 1'b0;
        end
    end

    for (genvar n = 0; n < `GEN_COUNT; n++) begin : g_generic
        assign req_vec[`VEC_GEN_BASE + n]      = generic_req_in[n];
        assign dma_vec[`VEC_GEN_BASE + n - 16] = generic_req_in[n];
    end

    assign req_vec[`VEC_SER8_RX]    = serial_hi_rx_in[0] | serial_hi_status_in[0] | capture16_in[0] | capture16_in[1];
    assign dma_vec[29]              = serial_hi_rx_in[0] | capture16_in[0] | capture16_in[1];
    assign req_vec[`VEC_OSC_TIMERS] = |osc_stab_timer_in | serial_hi_tx_in[0];
    assign dma_vec[30]              = |osc_stab_timer_in | serial_hi_tx_in[0];
    assign req_vec[`VEC_CAL_SUB]    = capture16_in[2] | capture16_in[3] | clk_cal_sub_in | serial_hi_rx_in[1];
    assign dma_vec[31]              = capture16_in[2] | capture16_in[3] | serial_hi_rx_in[1];
    assign req_vec[`VEC_CAL_RC]     = serial_hi_status_in[1] | (|adc_done_in) | clk_cal_rc_in;
    assign dma_vec[32]              = |adc_done_in;
    assign req_vec[`VEC_SER9_TX]    = serial_hi_tx_in[1] | compare16_in[0] | compare16_in[1];
    assign dma_vec[33]              = serial_hi_tx_in[1] | compare16_in[0] | compare16_in[1];
    assign req_vec[`VEC_FRT4]       = free_run32_in[4] | compare16_in[2] | compare16_in[3];
    assign dma_vec[34]              = compare16_in[2] | compare16_in[3];
    assign req_vec[`VEC_FRT35]      = free_run32_in[3] | free_run32_in[5] | compare16_in[4] | compare16_in[5];
    assign dma_vec[35]              = compare16_in[4] | compare16_in[5];
    assign req_vec[`VEC_SER10_RX]   = capture32_in[6] | serial_hi_rx_in[2] | serial_hi_status_in[2];
    assign dma_vec[36]              = capture32_in[6] | serial_hi_rx_in[2];
    assign req_vec[`VEC_SER10_TX]   = capture32_in[7] | serial_hi_tx_in[2];
    assign dma_vec[37]              = capture32_in[7] | serial_hi_tx_in[2];
    assign req_vec[`VEC_SER11_RX]   = capture32_in[8] | serial_hi_rx_in[3] | serial_hi_status_in[3];
    assign dma_vec[38]              = capture32_in[8] | serial_hi_rx_in[3];
    assign req_vec[`VEC_WAVE]       = capture32_in[9] | (|wave_dead_underflow_in) | (|wave_dead_reload_in);
    assign dma_vec[39]              = capture32_in[9] | (|wave_dead_underflow_in) | (|wave_dead_reload_in);
    assign req_vec[`VEC_TRIP]       = dead_time_trip_input_in | capture32_in[4] | serial_hi_tx_in[3];
    assign dma_vec[40]              = dead_time_trip_input_in | capture32_in[4] | serial_hi_tx_in[3];

    // vectors past the last mapped source carry no resource
    assign req_vec[`VEC_COUNT-1:`VEC_LAST_USED+1] = 7'h00;
    assign dma_vec[`RES_COUNT-1:`VEC_LAST_USED-15] = 7'h00;

    //--------------------------------------------------------------------------
    // selection
    //--------------------------------------------------------------------------

    logic                  sel_found;
    logic [`VEC_IDX_W-1:0] sel_idx;
    logic [`VEC_W-1:0]     sel_vec;
    logic                  sel_periph;
    logic                  sel_nmi;

    // exceptions and nmi sit below 16 so they beat every peripheral
    lowest_first #(
        .WIDTH (`VEC_COUNT),
        .IDX_W (`VEC_IDX_W)
    ) u_select (
        .req_in    (req_vec),
        .found_out (sel_found),
        .idx_out   (sel_idx)
    );

    assign sel_vec    = {2'b00, sel_idx};
    assign sel_periph = sel_vec >= `PERIPH_BASE;
    assign sel_nmi    = sel_vec == `VEC_W'(`VEC_NMI);

    //--------------------------------------------------------------------------
    // registered answer to the core and dma controller
    //--------------------------------------------------------------------------

    logic                        valid_nxt;
    logic [`ADDR_W-1:0]          addr_nxt;
    logic [`LEVEL_IDX_W-1:0]     level_idx_nxt;
    logic [`FIXED_LEVEL_W-1:0]   fixed_level_nxt;
    req_class_type               class_nxt;

    // drop valid for one cycle after an acknowledge so a stale vector is never offered twice
    assign valid_nxt       = sel_found && !irq_ack_in;
    assign addr_nxt        = vec_addr(vector_table_base_in, sel_vec);
    assign level_idx_nxt   = sel_periph ? periph_index(sel_vec) : `LEVEL_IDX_W'(0);
    assign fixed_level_nxt = sel_nmi ? `NMI_FIXED_LEVEL : `FIXED_LEVEL_W'(0);
    assign class_nxt       = !valid_nxt ? CLS_NONE :
                             sel_periph ? CLS_PERIPH :
                             sel_nmi    ? CLS_NMI : CLS_EXC;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_valid_out             <= 1'b0;
            irq_vector_out            <= '0;
            irq_vector_addr_out       <= '0;
            irq_level_index_out       <= '0;
            irq_level_index_valid_out <= 1'b0;
            irq_fixed_level_out       <= '0;
            irq_class_out             <= CLS_NONE;
        end else begin
            irq_valid_out             <= valid_nxt;
            irq_vector_out            <= sel_vec;
            irq_vector_addr_out       <= addr_nxt;
            irq_level_index_out       <= level_idx_nxt;
            irq_level_index_valid_out <= valid_nxt && sel_periph;
            irq_fixed_level_out       <= fixed_level_nxt;
            irq_class_out             <= class_nxt;
        end
    end

    // dma request lines indexed by resource number, vector minus 16
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dma_req_out <= '0;
        end else begin
            dma_req_out <= dma_vec;
        end
    end

endmodule : interrupt_vector_mapper

`default_nettype wire

/* File: testbench/ivm_core_model.sv */
// core model: acknowledges offered exception and nmi vectors after a set delay
`default_nettype none

module ivm_core_model
    import ivm_pkg::*;
(
    input  wire logic          mclk_in,
    input  wire logic          rst_in,
    input  wire logic          irq_valid_in,
    input  wire req_class_type irq_class_in,
    input  wire logic [3:0]    delay_in,
    output var  logic          irq_ack_out
);
    logic       ack_r;
    logic [3:0] cnt_r;
    logic       takes;

    // peripheral vectors are cleared at their source, never by the core
    assign takes       = irq_valid_in && (irq_class_in == CLS_EXC || irq_class_in == CLS_NMI) && !ack_r;
    assign irq_ack_out = ack_r;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            ack_r <= takes && cnt_r == delay_in;
            cnt_r <= (takes && cnt_r != delay_in) ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule : ivm_core_model

`default_nettype wire

/* File: testbench/interrupt_vector_mapper_asserts.sv */
// assertions on the ports of the interrupt vector mapper
`default_nettype none
`include "ivm_defs.svh"

module interrupt_vector_mapper_asserts
    import ivm_pkg::*;
(
    input wire logic                      mclk_in,
    input wire logic                      rst_in,
    input wire logic [`ADDR_W-1:0]        vector_table_base_in,
    input wire logic                      irq_ack_in,
    input wire logic                      irq_valid_out,
    input wire logic [`VEC_W-1:0]         irq_vector_out,
    input wire logic [`ADDR_W-1:0]        irq_vector_addr_out,
    input wire logic [`LEVEL_IDX_W-1:0]   irq_level_index_out,
    input wire logic                      irq_level_index_valid_out,
    input wire logic [`FIXED_LEVEL_W-1:0] irq_fixed_level_out,
    input wire req_class_type             irq_class_out,
    input wire logic [`RES_COUNT-1:0]     dma_req_out,
    input wire logic                      undef_instr_in,
    input wire logic                      timing_protection_viol_in,
    input wire logic [15:0]               ext_int_in,
    input wire logic                      low_voltage_det_in,
    input wire logic [7:0]                reload_timer_in,
    input wire logic [`SER_LO_CH-1:0]     serial_lo_rx_in,
    input wire logic [3:0]                capture16_in,
    input wire logic [3:0]                serial_hi_rx_in,
    input wire logic [31:0]               adc_done_in
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // vector, address and level
    // ------------------------------------------------------------
    a_addr_from_vector:
        assert property (irq_valid_out |->
            irq_vector_addr_out == $past(vector_table_base_in) + 32'h3fc - {irq_vector_out, 2'b00})
            else $error("vector address wrong");
    a_level_index_map:
        assert property (irq_level_index_valid_out |->
            irq_valid_out && irq_vector_out >= 8'h10 && irq_level_index_out == irq_vector_out[5:0] - 6'h10)
            else $error("level index wrong");
    a_nmi_fixed_level:
        assert property (irq_valid_out && irq_vector_out == 8'h0f |-> irq_fixed_level_out == 5'h0f)
            else $error("nmi level not fixed");
    a_undef_raised:
        assert property (undef_instr_in ##1 !irq_ack_in |=>
            irq_valid_out && irq_vector_out <= 8'h0e && irq_class_out == CLS_EXC)
            else $error("undefined instruction not raised");
    a_nmi_raised:
        assert property (timing_protection_viol_in ##1 !irq_ack_in |=>
            irq_valid_out && irq_vector_out <= 8'h0f && irq_class_out != CLS_PERIPH)
            else $error("nmi not raised");

    // ------------------------------------------------------------
    // dma requests
    // ------------------------------------------------------------
    a_low_voltage_nodma:
        assert property (low_voltage_det_in && ext_int_in[15:8] == 8'h00 |=> !dma_req_out[1])
            else $error("low voltage raised dma");
    a_reload_hi_nodma:
        assert property (reload_timer_in[1:0] == 2'b00 |=> !dma_req_out[2])
            else $error("reload timer 4 or 5 raised dma");
    a_cal_nodma:
        assert property (capture16_in[3:2] == 2'b00 && !serial_hi_rx_in[1] |=> !dma_req_out[31])
            else $error("clock calibration raised dma");
    a_status_nodma:
        assert property (!serial_lo_rx_in[0] |=> !dma_req_out[4])
            else $error("serial status raised dma");
    a_unassigned_nodma:
        assert property (dma_req_out[47:41] == 7'h00 && dma_req_out[17:15] == 3'h0)
            else $error("dma without resource");
    a_adc_dma:
        assert property (adc_done_in != 32'h0 |=> dma_req_out[32])
            else $error("converter dma missing");
endmodule : interrupt_vector_mapper_asserts

bind interrupt_vector_mapper interrupt_vector_mapper_asserts chk_i (
    .mclk_in, .rst_in, .vector_table_base_in, .irq_ack_in, .irq_valid_out, .irq_vector_out,
    .irq_vector_addr_out, .irq_level_index_out, .irq_level_index_valid_out, .irq_fixed_level_out,
    .irq_class_out, .dma_req_out, .undef_instr_in, .timing_protection_viol_in, .ext_int_in,
    .low_voltage_det_in, .reload_timer_in, .serial_lo_rx_in, .capture16_in, .serial_hi_rx_in, .adc_done_in
);

`default_nettype wire

/* File: testbench/tb_interrupt_vector_mapper.sv */
// testbench of the interrupt vector mapper with a core model on the far side
`default_nettype none
`include "ivm_defs.svh"

module tb_interrupt_vector_mapper
    import ivm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          mclk_in, rst_in, irq_ack_in, irq_valid_out, irq_level_index_valid_out;
    logic [31:0]   vector_table_base_in, irq_vector_addr_out;
    logic [7:0]    irq_vector_out, ev_r;
    logic [5:0]    irq_level_index_out;
    logic [4:0]    irq_fixed_level_out;
    logic [47:0]   dma_req_out;
    logic [25:0]   src_r;
    logic [3:0]    delay_r;
    req_class_type irq_class_out;
    int            n_mismatch, compares;
    // expected vector and dma bit per source bit, 8'hff for no dma
    logic [7:0]    pv_t [26] = '{8'h10, 8'h11, 8'h11, 8'h12, 8'h12, 8'h14, 8'h14, 8'h15, 8'h1f, 8'h22, 8'h2d,
        8'h2d, 8'h2d, 8'h2e, 8'h2e, 8'h2f, 8'h30, 8'h30, 8'h32, 8'h32, 8'h33, 8'h37, 8'h37, 8'h37, 8'h38, 8'h1c};
    logic [7:0]    pd_t [26] = '{8'h00, 8'h01, 8'hff, 8'h02, 8'hff, 8'h04, 8'hff, 8'h05, 8'hff, 8'h12, 8'h1d,
        8'h1d, 8'hff, 8'h1e, 8'h1e, 8'hff, 8'hff, 8'h20, 8'h22, 8'hff, 8'hff, 8'h27, 8'h27, 8'h27, 8'h28, 8'h0c};

    interrupt_vector_mapper dut (
        .mclk_in, .rst_in, .vector_table_base_in, .irq_ack_in, .irq_valid_out, .irq_vector_out,
        .irq_vector_addr_out, .irq_level_index_out, .irq_level_index_valid_out, .irq_fixed_level_out,
        .irq_class_out, .dma_req_out,
        .instr_prot_viol_in(ev_r[0]), .data_prot_viol_in(ev_r[1]), .data_access_err_in(ev_r[2]),
        .undef_instr_in(ev_r[3]), .bus_diag_err_in(ev_r[4]), .crossbar_ram_dbl_err_in(ev_r[5]),
        .backup_ram_dbl_err_in(ev_r[6]), .timing_protection_viol_in(ev_r[7]),
        .ext_int_in({7'h00, src_r[1], 7'h00, src_r[0]}), .low_voltage_det_in(src_r[2]),
        .reload_timer_in({3'h0, src_r[4], 3'h0, src_r[3]}), .serial_lo_rx_in({3'h0, src_r[5]}),
        .serial_lo_status_in({3'h0, src_r[6]}), .serial_lo_tx_in({3'h0, src_r[7]}),
        .pulse_gen_in({23'h0, src_r[8], 23'h0, src_r[25]}), .generic_req_in({10'h000, src_r[9]}),
        .capture16_in({3'h0, src_r[10]}), .serial_hi_rx_in({3'h0, src_r[11]}),
        .serial_hi_status_in({3'h0, src_r[12]}), .serial_hi_tx_in({3'h0, src_r[13]}),
        .osc_stab_timer_in({1'b0, src_r[14], 1'b0}), .clk_cal_sub_in(src_r[15]), .clk_cal_rc_in(src_r[16]),
        .adc_done_in({28'h0, src_r[17], 3'h0}), .compare16_in({3'h0, src_r[18], 2'h0}),
        .capture32_in({src_r[21], 5'h00}), .free_run32_in({1'b0, src_r[19], src_r[20]}),
        .wave_dead_underflow_in({src_r[22], 2'h0}), .wave_dead_reload_in({2'h0, src_r[23]}),
        .dead_time_trip_input_in(src_r[24])
    );

    ivm_core_model core (.mclk_in, .rst_in, .irq_valid_in(irq_valid_out), .irq_class_in(irq_class_out),
        .delay_in(delay_r), .irq_ack_out(irq_ack_in));

    // ------------------------------------------------------------
    // clock, compare and closing
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_exceptions;
        logic [7:0]  ev_vec [8] = '{8'h06, 8'h07, 8'h08, 8'h0e, 8'h0f, 8'h0f, 8'h0f, 8'h0f};
        logic [11:0] ev_off [8] = '{12'h3e4, 12'h3e0, 12'h3dc, 12'h3c4, 12'h3c0, 12'h3c0, 12'h3c0, 12'h3c0};
        @(posedge mclk_in) delay_r <= 4'h3;
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk_in) ev_r <= 8'h01 << k;
            @(posedge mclk_in) ev_r <= 8'h00;
            @(posedge mclk_in) #1;
            chk(irq_vector_out, ev_vec[k]);
            chk(irq_vector_addr_out, vector_table_base_in + ev_off[k]);
            chk({irq_valid_out, irq_class_out}, {1'b1, k < 4 ? CLS_EXC : CLS_NMI});
            chk({irq_level_index_valid_out, irq_fixed_level_out}, k < 4 ? 6'h00 : 6'h0f);
            for (int i = 0; i < 10 && irq_ack_in !== 1'b1; i++) @(posedge mclk_in) #1;
            chk({irq_ack_in, irq_vector_out}, {1'b1, ev_vec[k]});
            @(posedge mclk_in) #1;
            chk({irq_valid_out, irq_class_out}, {1'b0, CLS_NONE});
        end
    endtask : t_exceptions

    task automatic t_priority;
        logic [7:0] seen [$];
        @(posedge mclk_in) begin
            delay_r <= 4'h0;
            ev_r    <= 8'h1a;
            src_r   <= 26'h1;
        end
        @(posedge mclk_in) ev_r <= 8'h00;
        for (int i = 0; i < 30 && seen.size() < 4; i++) begin
            @(posedge mclk_in) #1;
            if (irq_valid_out === 1'b1 && (seen.size() == 0 || seen[$] !== irq_vector_out))
                seen.push_back(irq_vector_out);
        end
        chk({seen[0], seen[1], seen[2], seen[3]}, 32'h070e0f10);
        chk({irq_level_index_out, dma_req_out}, 54'h1);
        @(posedge mclk_in) src_r <= 26'h0;
    endtask : t_priority

    task automatic t_periph;
        @(posedge mclk_in) vector_table_base_in <= 32'h2000_0000;
        for (int k = 0; k < 26; k++) begin
            @(posedge mclk_in) src_r <= 26'h1 << k;
            @(posedge mclk_in) #1;
            chk(irq_vector_out, pv_t[k]);
            chk(irq_vector_addr_out, vector_table_base_in + 32'h3fc - {pv_t[k], 2'b00});
            chk(irq_level_index_out, pv_t[k] - 8'h10);
            chk({irq_valid_out, irq_level_index_valid_out, irq_class_out}, {2'b11, CLS_PERIPH});
            chk(dma_req_out, pd_t[k] == 8'hff ? 48'h0 : 48'h1 << pd_t[k]);
            @(posedge mclk_in) src_r <= 26'h0;
        end
        @(posedge mclk_in) #1;
        chk({irq_valid_out, dma_req_out}, 49'h0);
    endtask : t_periph

    task automatic t_reset;
        @(posedge mclk_in) ev_r <= 8'h08;
        @(posedge mclk_in) ev_r <= 8'h00;
        @(posedge mclk_in) rst_in <= 1'b1;
        @(posedge mclk_in) rst_in <= 1'b0;
        @(posedge mclk_in) #1;
        chk({irq_valid_out, irq_class_out, irq_vector_out, dma_req_out}, {1'b0, CLS_NONE, 8'h00, 48'h0});
    endtask : t_reset

    initial begin
        rst_in = 1'b1;
        ev_r = 8'h00;
        src_r = 26'h0;
        delay_r = 4'h0;
        vector_table_base_in = 32'h000f_fc00;
        n_mismatch = 0;
        compares = 0;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_exceptions();
        t_priority();
        t_periph();
        t_reset();
        wrap_up();
    end

    initial begin
        repeat (2000) @(posedge mclk_in);
        n_mismatch++;
        wrap_up();
    end
endmodule : tb_interrupt_vector_mapper

`default_nettype wire
